/* File: rtl/ggat_defines.svh */
// register offsets, reset values and field positions of the alert block
// assumes inclusion by bare name from the design files
`ifndef GGAT_DEFINES_SVH
`define GGAT_DEFINES_SVH
`define GGAT_OFS_VLIM 8'h01
`define GGAT_OFS_TLIM 8'h02
`define GGAT_OFS_SLIM 8'h03
`define GGAT_OFS_TEMP 8'h08
`define GGAT_OFS_EXTR 8'h1A
`define GGAT_OFS_JUNC 8'h34
`define GGAT_OFS_PWR 8'hB1
`define GGAT_OFS_APWR 8'hB3
`define GGAT_OFS_ILIM 8'hB4
`define GGAT_OFS_SN0 8'hD4
`define GGAT_OFS_SN1 8'hD5
`define GGAT_OFS_SN2 8'hD9
`define GGAT_OFS_SN3 8'hDA
`define GGAT_OFS_SN4 8'hDC
`define GGAT_OFS_SN5 8'hDD
`define GGAT_OFS_SN6 8'hDE
`define GGAT_OFS_SN7 8'hDF
`define GGAT_RST_VLIM 16'hFF00
`define GGAT_RST_TLIM 16'h7F80
`define GGAT_RST_SLIM 16'hFF00
`define GGAT_RST_ILIM 16'h7F80
`define GGAT_RST_EXTR 16'h807F
`define GGAT_STEP_BIT 8
`define GGAT_POWER_SHIFT 16
`define GGAT_AVG_SHIFT 4
`endif

/* File: rtl/ggat_pkg.sv */
// shared types of the alert block
// assumes nothing of its surroundings
package ggat_pkg;
  typedef logic [7:0] ggat_byte_t;
  typedef logic [15:0] ggat_word_t;
  // index of each threshold source in the flag vector
  typedef enum logic [1:0] {
    GGAT_SRC_VOLT = 2'b00,
    GGAT_SRC_TEMP = 2'b01,
    GGAT_SRC_CURR = 2'b10,
    GGAT_SRC_CHRG = 2'b11
  } ggat_src_t;
endpackage

/* File: rtl/ggat_limit_cmp.sv */
// one upper/lower byte limit check with latched or self-releasing flag
// assumes update, reading and limits come from the same clock domain
`timescale 1ns/1ps
module ggat_limit_cmp
  import ggat_pkg::*;
#(
  parameter bit SIGNED_CMP = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // reading and limits
  input wire logic update,
  input wire ggat_byte_t reading,
  input wire ggat_byte_t upper_limit,
  input wire ggat_byte_t lower_limit,
  // control
  input wire logic enable,
  input wire logic latched,
  input wire logic clear,
  // result
  output logic flag_r
);
  logic above;
  logic below;

  always_comb begin
    if (SIGNED_CMP) begin
      above = $signed(reading) > $signed(upper_limit);
      below = $signed(reading) < $signed(lower_limit);
    end else begin
      above = reading > upper_limit;
      below = reading < lower_limit;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else if (!enable) begin
      flag_r <= 1'b0;
    end else if (update && (above || below)) begin
      flag_r <= 1'b1;
    end else if (update && !latched) begin
      flag_r <= 1'b0;
    end else if (clear) begin
      flag_r <= 1'b0;
    end
  end
endmodule // ggat_limit_cmp

/* File: rtl/ggat_alert_top.sv */
// alert, limit, power, extremes and serial overlay logic of the gauge
// assumes front-end readings and strobes on clock; aux levels are async
`timescale 1ns/1ps
`include "ggat_defines.svh"
module ggat_alert_top
  import ggat_pkg::*;
#(
  // arbitrary value, not a real part's number
  parameter logic [127:0] SERIAL_NUMBER = 128'h0123456789ABCDEF0F1E2D3C4B5A6978,
  parameter int POWER_SHIFT = `GGAT_POWER_SHIFT,
  parameter int AVG_SHIFT = `GGAT_AVG_SHIFT
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire ggat_word_t reg_wdata,
  input wire logic reg_rd_en,
  output ggat_word_t reg_rdata,
  // readings from the front end
  input wire ggat_word_t cell_voltage_reading,
  input wire logic voltage_update,
  input wire ggat_word_t current_reading,
  input wire logic current_update,
  input wire ggat_word_t die_temp_reading,
  input wire logic die_temp_update,
  input wire ggat_word_t thermistor_reading,
  input wire logic thermistor_update,
  input wire ggat_word_t reported_charge_level,
  input wire logic charge_update,
  // auxiliary input comparators, asynchronous
  input wire logic aux_above_removal,
  input wire logic aux_below_insertion,
  // configuration bits
  input wire logic threshold_alert_enable,
  input wire logic alert_latched_mode,
  input wire logic removal_detect_enable,
  input wire logic insertion_detect_enable,
  input wire logic temperature_source_select,
  input wire logic charge_step_alert_enable,
  input wire logic rate_prediction_enable,
  input wire logic dynamic_power_enable,
  // status flag clears
  input wire logic removal_flag_clear,
  input wire logic insertion_flag_clear,
  input wire logic threshold_flag_clear,
  input wire logic charge_step_flag_clear,
  // normal results behind the serial overlay
  input wire logic [127:0] peak_result_words,
  // status flags
  output logic removal_flag,
  output logic insertion_flag,
  output logic charge_step_flag,
  output logic [3:0] threshold_flags,
  // alert pin
  output logic alert_pin_out,
  output logic alert_pin_oe
);
  localparam logic [7:0] SN_OFS [8] = '{
    `GGAT_OFS_SN0, `GGAT_OFS_SN1, `GGAT_OFS_SN2, `GGAT_OFS_SN3,
    `GGAT_OFS_SN4, `GGAT_OFS_SN5, `GGAT_OFS_SN6, `GGAT_OFS_SN7};

  ggat_word_t vlim_r;
  ggat_word_t tlim_r;
  ggat_word_t slim_r;
  ggat_word_t ilim_r;
  ggat_word_t extremes_r;
  ggat_word_t junction_r;
  ggat_word_t temperature_r;
  ggat_word_t volt_r;
  ggat_word_t curr_r;
  ggat_word_t power_r;
  ggat_word_t avg_power_r;
  logic power_upd_r;
  logic avg_upd_r;
  logic rem_s1_r;
  logic rem_s2_r;
  logic rem_s3_r;
  logic ins_s1_r;
  logic ins_s2_r;
  logic ins_s3_r;
  logic step_bit_r;
  logic step_seen_r;
  logic temp_update;
  ggat_word_t temp_value;
  ggat_byte_t temp_byte;
  logic rem_rise;
  logic ins_rise;
  logic step_change;
  logic serial_mode;
  logic pend;
  logic signed [32:0] product;
  logic signed [16:0] avg_diff;
  ggat_word_t rd_nxt;
  logic [3:0] thr_flags;

  always_comb begin
    temp_update = temperature_source_select ? thermistor_update :
      die_temp_update;
    temp_value = temperature_source_select ? thermistor_reading :
      die_temp_reading;
    temp_byte = temp_value[15:8];
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      junction_r <= 16'h0000;
      temperature_r <= 16'h0000;
    end else begin
      if (die_temp_update) begin
        junction_r <= die_temp_reading;
      end
      if (temp_update) begin
        temperature_r <= temp_value;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vlim_r <= `GGAT_RST_VLIM;
      tlim_r <= `GGAT_RST_TLIM;
      slim_r <= `GGAT_RST_SLIM;
      ilim_r <= `GGAT_RST_ILIM;
    end else if (reg_wr_en) begin
      if (reg_addr == `GGAT_OFS_VLIM) vlim_r <= reg_wdata;
      if (reg_addr == `GGAT_OFS_TLIM) tlim_r <= reg_wdata;
      if (reg_addr == `GGAT_OFS_SLIM) slim_r <= reg_wdata;
      if (reg_addr == `GGAT_OFS_ILIM) ilim_r <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      extremes_r <= `GGAT_RST_EXTR;
    end else if (reg_wr_en && reg_addr == `GGAT_OFS_EXTR) begin
      extremes_r <= reg_wdata;
    end else if (temp_update) begin
      if ($signed(temp_byte) > $signed(extremes_r[15:8])) begin
        extremes_r[15:8] <= temp_byte;
      end
      if ($signed(temp_byte) < $signed(extremes_r[7:0])) begin
        extremes_r[7:0] <= temp_byte;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      volt_r <= 16'h0000;
      curr_r <= 16'h0000;
      power_upd_r <= 1'b0;
      power_r <= 16'h0000;
    end else begin
      if (voltage_update) volt_r <= cell_voltage_reading;
      if (current_update) curr_r <= current_reading;
      power_upd_r <= voltage_update | current_update;
      if (power_upd_r) power_r <= product[POWER_SHIFT +: 16];
    end
  end

  always_comb begin
    product = $signed({1'b0, volt_r}) * $signed(curr_r);
    avg_diff = $signed({power_r[15], power_r}) -
      $signed({avg_power_r[15], avg_power_r});
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      avg_upd_r <= 1'b0;
      avg_power_r <= 16'h0000;
    end else begin
      avg_upd_r <= power_upd_r;
      if (avg_upd_r) begin
        avg_power_r <= avg_power_r + 16'(avg_diff >>> AVG_SHIFT);
      end
    end
  end

  // aux comparator synchronisers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rem_s1_r <= 1'b0;
      rem_s2_r <= 1'b0;
      rem_s3_r <= 1'b0;
      ins_s1_r <= 1'b0;
      ins_s2_r <= 1'b0;
      ins_s3_r <= 1'b0;
    end else begin
      rem_s1_r <= aux_above_removal;
      rem_s2_r <= rem_s1_r;
      rem_s3_r <= rem_s2_r;
      ins_s1_r <= aux_below_insertion;
      ins_s2_r <= ins_s1_r;
      ins_s3_r <= ins_s2_r;
    end
  end

  assign rem_rise = rem_s2_r & ~rem_s3_r;
  assign ins_rise = ins_s2_r & ~ins_s3_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      removal_flag <= 1'b1;
    end else if (rem_rise && removal_detect_enable) begin
      removal_flag <= 1'b1;
    end else if (removal_flag_clear) begin
      removal_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      insertion_flag <= 1'b0;
    end else if (ins_rise && insertion_detect_enable) begin
      insertion_flag <= 1'b1;
    end else if (insertion_flag_clear) begin
      insertion_flag <= 1'b0;
    end
  end

  assign step_change = charge_update && step_seen_r &&
    (reported_charge_level[`GGAT_STEP_BIT] != step_bit_r);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      step_bit_r <= 1'b0;
      step_seen_r <= 1'b0;
      charge_step_flag <= 1'b0;
    end else begin
      if (charge_update) begin
        step_bit_r <= reported_charge_level[`GGAT_STEP_BIT];
        step_seen_r <= 1'b1;
      end
      if (step_change && charge_step_alert_enable) begin
        charge_step_flag <= 1'b1;
      end else if (charge_step_flag_clear) begin
        charge_step_flag <= 1'b0;
      end
    end
  end

  ggat_limit_cmp #(.SIGNED_CMP(1'b0)) u_volt (
    .clock(clock),
    .reset_n(reset_n),
    .update(voltage_update),
    .reading(cell_voltage_reading[15:8]),
    .upper_limit(vlim_r[15:8]),
    .lower_limit(vlim_r[7:0]),
    .enable(threshold_alert_enable),
    .latched(alert_latched_mode),
    .clear(threshold_flag_clear),
    .flag_r(thr_flags[GGAT_SRC_VOLT])
  );

  ggat_limit_cmp #(.SIGNED_CMP(1'b1)) u_temp (
    .clock(clock),
    .reset_n(reset_n),
    .update(temp_update),
    .reading(temp_byte),
    .upper_limit(tlim_r[15:8]),
    .lower_limit(tlim_r[7:0]),
    .enable(threshold_alert_enable),
    .latched(alert_latched_mode),
    .clear(threshold_flag_clear),
    .flag_r(thr_flags[GGAT_SRC_TEMP])
  );

  ggat_limit_cmp #(.SIGNED_CMP(1'b1)) u_curr (
    .clock(clock),
    .reset_n(reset_n),
    .update(current_update),
    .reading(current_reading[15:8]),
    .upper_limit(ilim_r[15:8]),
    .lower_limit(ilim_r[7:0]),
    .enable(threshold_alert_enable),
    .latched(alert_latched_mode),
    .clear(threshold_flag_clear),
    .flag_r(thr_flags[GGAT_SRC_CURR])
  );

  ggat_limit_cmp #(.SIGNED_CMP(1'b0)) u_chrg (
    .clock(clock),
    .reset_n(reset_n),
    .update(charge_update),
    .reading(reported_charge_level[15:8]),
    .upper_limit(slim_r[15:8]),
    .lower_limit(slim_r[7:0]),
    .enable(threshold_alert_enable),
    .latched(alert_latched_mode),
    .clear(threshold_flag_clear),
    .flag_r(thr_flags[GGAT_SRC_CHRG])
  );

  assign threshold_flags = thr_flags;

  assign pend = (|thr_flags) | charge_step_flag |
    (removal_flag & removal_detect_enable) |
    (insertion_flag & insertion_detect_enable);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alert_pin_out <= 1'b0;
      alert_pin_oe <= 1'b0;
    end else begin
      alert_pin_out <= 1'b0;
      alert_pin_oe <= pend;
    end
  end

  assign serial_mode = ~rate_prediction_enable & ~dynamic_power_enable;

  always_comb begin
    rd_nxt = 16'h0000;
    case (reg_addr)
      `GGAT_OFS_VLIM: rd_nxt = vlim_r;
      `GGAT_OFS_TLIM: rd_nxt = tlim_r;
      `GGAT_OFS_SLIM: rd_nxt = slim_r;
      `GGAT_OFS_ILIM: rd_nxt = ilim_r;
      `GGAT_OFS_TEMP: rd_nxt = temperature_r;
      `GGAT_OFS_EXTR: rd_nxt = extremes_r;
      `GGAT_OFS_JUNC: rd_nxt = junction_r;
      `GGAT_OFS_PWR: rd_nxt = power_r;
      `GGAT_OFS_APWR: rd_nxt = avg_power_r;
      default: rd_nxt = 16'h0000;
    endcase
    for (int i = 0; i < 8; i++) begin
      if (reg_addr == SN_OFS[i]) begin
        rd_nxt = serial_mode ? SERIAL_NUMBER[i*16 +: 16] :
          peak_result_words[i*16 +: 16];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd_en) begin
      reg_rdata <= rd_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  junction_track_a: assert property (
    die_temp_update |=> junction_r == $past(die_temp_reading))
    else $error("junction register missed a die reading");

  temp_mirror_a: assert property (
    !temperature_source_select && die_temp_update
    |=> temperature_r == junction_r)
    else $error("temperature not mirroring die sensor");

  removal_set_a: assert property (
    rem_rise && removal_detect_enable |=> removal_flag)
    else $error("removal not flagged");

  insert_hold_a: assert property (
    insertion_flag && !insertion_flag_clear |=> insertion_flag)
    else $error("insertion flag released without clear");

  volt_over_a: assert property (
    threshold_alert_enable && voltage_update &&
    cell_voltage_reading[15:8] > vlim_r[15:8]
    |=> thr_flags[0] ##1 alert_pin_oe)
    else $error("voltage over limit not alerted");

  auto_release_a: assert property (
    threshold_alert_enable && !alert_latched_mode && voltage_update &&
    cell_voltage_reading[15:8] <= vlim_r[15:8] &&
    cell_voltage_reading[15:8] >= vlim_r[7:0] |=> !thr_flags[0])
    else $error("voltage flag not released");

  step_alert_a: assert property (
    step_change && charge_step_alert_enable
    |=> charge_step_flag ##1 alert_pin_oe)
    else $error("charge step not alerted");

  alert_release_a: assert property (
    !pend [*2] |-> !alert_pin_oe)
    else $error("alert held with nothing pending");

  extremes_max_a: assert property (
    temp_update && !reg_wr_en &&
    $signed(temp_byte) > $signed(extremes_r[15:8])
    |=> extremes_r[15:8] == $past(temp_byte))
    else $error("highest temperature not captured");

  serial_word_a: assert property (
    reg_rd_en && serial_mode && reg_addr == `GGAT_OFS_SN7
    |=> reg_rdata == SERIAL_NUMBER[127:112])
    else $error("serial word 7 wrong");

  power_avg_a: assert property (
    avg_upd_r &&
    $signed(power_r) - $signed(avg_power_r) >= (1 << AVG_SHIFT)
    |=> $signed(avg_power_r) > $signed($past(avg_power_r)) &&
    $signed(avg_power_r) <= $signed($past(power_r)))
    else $error("average not moving toward instant power");

  removal_cov: cover property (rem_rise && removal_detect_enable);
  volt_cov: cover property (thr_flags[0] && alert_pin_oe);
  serial_cov: cover property (reg_rd_en && serial_mode);
  step_cov: cover property (charge_step_flag);
endmodule // ggat_alert_top

/* File: testbench/ggat_host_model.sv */
// host side of the alert pin: pulled-up interrupt input
// assumes pin data and enable come straight from the gauge
`timescale 1ns/1ps
module ggat_host_model (
  // alert pin from the gauge
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe,
  // level seen by the host
  output logic alert_level
);
  assign alert_level = alert_pin_oe ? alert_pin_out : 1'h1;
endmodule // ggat_host_model

/* File: testbench/gauge_alert_thresholds_tb_top.sv */
// self-checking bench of the gauge alert block
// assumes the plain register port and a pulled-up host input
`timescale 1ns/1ps
module gauge_alert_thresholds_tb_top;
  import ggat_pkg::*;
  // arbitrary serial value and normal result words
  localparam logic [127:0] SN = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] PK = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'h0;
  logic reg_rd_en = 1'h0;
  ggat_word_t reg_wdata = 16'h0000;
  ggat_word_t reg_rdata;
  ggat_word_t rdg = 16'h0000;
  logic [4:0] upd = 5'h00;
  logic [3:0] clr = 4'h0;
  logic [1:0] aux = 2'h0;
  logic [1:0] det_en = 2'h0;
  logic thr_en = 1'h0;
  logic latch = 1'h0;
  logic sel = 1'h0;
  logic step_en = 1'h0;
  logic rate_en = 1'h1;
  logic dyn_en = 1'h1;
  wire [1:0] flg;
  wire charge_step_flag;
  wire [3:0] threshold_flags;
  wire alert_pin_out;
  wire alert_pin_oe;
  wire alert_level;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] rst_ofs [5] = '{8'h01, 8'h02, 8'h03, 8'hB4, 8'h1A};
  ggat_word_t rst_val [5] = '{16'hFF00, 16'h7F80, 16'hFF00, 16'h7F80,
    16'h807F};
  logic [7:0] lim_ofs [4] = '{8'h01, 8'h02, 8'hB4, 8'h03};
  ggat_word_t lim_val [4] = '{16'h8010, 16'h05FB, 16'h05FB, 16'h5A0A};
  ggat_byte_t tv [4][5] = '{'{8'h81, 8'h80, 8'h0F, 8'hFF, 8'h10},
    '{8'h06, 8'h05, 8'hFA, 8'hFC, 8'hFB},
    '{8'h06, 8'h05, 8'hFA, 8'hFC, 8'hFB},
    '{8'h5B, 8'h5A, 8'h09, 8'hC8, 8'h0A}};
  logic [4:0] te [4] = '{5'h0D, 5'h05, 5'h05, 5'h0D};
  logic [7:0] sn_ofs [8] = '{8'hD4, 8'hD5, 8'hD9, 8'hDA, 8'hDC, 8'hDD,
    8'hDE, 8'hDF};

  always #5 clock = ~clock;

  ggat_alert_top #(.SERIAL_NUMBER(SN)) uut (
    .clock, .reset_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
    .reg_rdata, .cell_voltage_reading(rdg), .voltage_update(upd[0]),
    .current_reading(rdg), .current_update(upd[2]),
    .die_temp_reading(rdg), .die_temp_update(upd[1]),
    .thermistor_reading(rdg), .thermistor_update(upd[4]),
    .reported_charge_level(rdg), .charge_update(upd[3]),
    .aux_above_removal(aux[0]), .aux_below_insertion(aux[1]),
    .threshold_alert_enable(thr_en), .alert_latched_mode(latch),
    .removal_detect_enable(det_en[0]),
    .insertion_detect_enable(det_en[1]),
    .temperature_source_select(sel), .charge_step_alert_enable(step_en),
    .rate_prediction_enable(rate_en), .dynamic_power_enable(dyn_en),
    .removal_flag_clear(clr[0]), .insertion_flag_clear(clr[1]),
    .threshold_flag_clear(clr[2]), .charge_step_flag_clear(clr[3]),
    .peak_result_words(PK), .removal_flag(flg[0]),
    .insertion_flag(flg[1]), .charge_step_flag, .threshold_flags,
    .alert_pin_out, .alert_pin_oe
  );

  ggat_host_model host (.alert_pin_out, .alert_pin_oe, .alert_level);

  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(ggat_word_t got, ggat_word_t exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, ggat_word_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'h1;
    tick();
    reg_wr_en = 1'h0;
  endtask

  task automatic rdc(logic [7:0] a, ggat_word_t exp);
    reg_addr = a;
    reg_rd_en = 1'h1;
    tick();
    reg_rd_en = 1'h0;
    tick();
    chk(reg_rdata, exp);
  endtask

  // one reading update pulse, then let flags and pin settle
  task automatic feed(int s, ggat_byte_t v);
    rdg = {v, 8'h00};
    upd[s] = 1'h1;
    tick();
    upd = 5'h00;
    tick(2);
  endtask

  task automatic pulse(int i);
    clr[i] = 1'h1;
    tick();
    clr = 4'h0;
    tick(2);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge clock);
    #1;
    reset_n = 1'h1;
    for (int i = 0; i < 5; i++)
      rdc(rst_ofs[i], rst_val[i]);
    rdc(8'h05, 16'h0000);
    wr(8'h34, 16'hABCD);
    rdc(8'h34, 16'h0000);
    rdg = 16'h1000;
    upd = 5'h05;
    tick();
    upd = 5'h00;
    tick(3);
    rdc(8'hB1, 16'h0100);
    rdc(8'hB3, 16'h0010);
    chkb(flg[0], 1'h1);
    chkb(alert_level, 1'h1);
    det_en[0] = 1'h1;
    tick(3);
    chkb(alert_level, 1'h0);
    for (int i = 0; i < 2; i++) begin
      det_en[i] = 1'h1;
      pulse(i);
      chkb(flg[i], 1'h0);
      chkb(alert_level, 1'h1);
      aux[i] = 1'h1;
      tick(6);
      chkb(flg[i], 1'h1);
      chkb(alert_level, 1'h0);
      aux[i] = 1'h0;
      tick(6);
      chkb(flg[i], 1'h1);
      pulse(i);
      chkb(flg[i], 1'h0);
      det_en[i] = 1'h0;
    end
    aux[1] = 1'h1;
    tick(6);
    chkb(alert_level, 1'h1);
    aux[1] = 1'h0;
    tick(6);
    pulse(1);
    for (int s = 0; s < 4; s++) begin
      wr(lim_ofs[s], lim_val[s]);
      rdc(lim_ofs[s], lim_val[s]);
    end
    feed(0, 8'h81);
    chkb(threshold_flags[0], 1'h0);
    chkb(alert_level, 1'h1);
    thr_en = 1'h1;
    // strict compares, signed for temp and current
    for (int s = 0; s < 4; s++)
      for (int j = 0; j < 5; j++) begin
        feed(s, tv[s][j]);
        chkb(threshold_flags[s], te[s][j]);
        chkb(alert_level, ~te[s][j]);
      end
    latch = 1'h1;
    feed(0, 8'h81);
    feed(0, 8'h10);
    chkb(threshold_flags[0], 1'h1);
    pulse(2);
    chkb(threshold_flags[0], 1'h0);
    chkb(alert_level, 1'h1);
    latch = 1'h0;
    step_en = 1'h1;
    feed(3, 8'h0B);
    chkb(charge_step_flag, 1'h1);
    chkb(alert_level, 1'h0);
    pulse(3);
    chkb(charge_step_flag, 1'h0);
    step_en = 1'h0;
    feed(3, 8'h0C);
    chkb(alert_level, 1'h1);
    wr(8'h1A, 16'h807F);
    rdc(8'h1A, 16'h807F);
    feed(1, 8'h10);
    feed(1, 8'hF0);
    feed(1, 8'h05);
    rdc(8'h1A, 16'h10F0);
    feed(1, 8'h12);
    rdc(8'h34, 16'h1200);
    rdc(8'h08, 16'h1200);
    sel = 1'h1;
    feed(4, 8'h03);
    rdc(8'h08, 16'h0300);
    rdc(8'h34, 16'h1200);
    sel = 1'h0;
    // serial overlay, ends with both enables set
    for (int m = 0; m < 4; m++) begin
      {rate_en, dyn_en} = m[1:0];
      for (int i = 0; i < 8; i++)
        rdc(sn_ofs[i], (m == 0) ? SN[16*i +: 16] : PK[16*i +: 16]);
    end
    tally_and_finish();
  end
endmodule // gauge_alert_thresholds_tb_top
